// ---- bpao_map.vh ----
/*
  Register offsets, field positions, reset values and coding constants
  of the bi-phase digital audio transmitter.
  Assumes inclusion by bare name from the design files.
*/
`ifndef BPAO_MAP_VH
`define BPAO_MAP_VH

`define BPAO_ADR_CTRL     8'h00
`define BPAO_ADR_STAT     8'h04

`define BPAO_CTRL_SRC_LSB 0
`define BPAO_CTRL_SRC_MSB 1
`define BPAO_CTRL_FLAG    2
`define BPAO_CTRL_ACC_LSB 3
`define BPAO_CTRL_ACC_MSB 4
`define BPAO_CTRL_RST     5'h00

`define BPAO_SRC_OFF      2'h0
`define BPAO_SRC_PRE      2'h1
`define BPAO_SRC_POST     2'h2

`define BPAO_ACC_LVL1     2'h0
`define BPAO_ACC_LVL2     2'h1
`define BPAO_ACC_LVL3     2'h2

`define BPAO_PRE_BLOCK    8'he8
`define BPAO_PRE_LEFT     8'he2
`define BPAO_PRE_RIGHT    8'he4

`define BPAO_LAST_FRAME   8'hbf
`define BPAO_LAST_SLOT    6'h3f
`define BPAO_PRE_SLOTS    6'h08

`endif

// ---- bpao_bmc_enc.v ----
/*
  Bi-phase mark line encoder: one half-cell per tick, preamble patterns
  in half-cells 0 to 7, data cells 4 to 31 after them.
  Assumes word and preamble are stable across a subframe's ticks; slot steps once per tick.
*/
`timescale 1ns/1ns
`include "bpao_map.vh"

module bpao_bmc_enc
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        tick_i,
  input  wire [5:0]  slot_i,
  input  wire [31:0] word_i,
  input  wire [7:0]  pre_i,
  output reg         line_o
);

  reg  inv_r;
  wire inv_now;
  wire pre_lvl;

  // Preamble polarity follows the level left by the previous subframe
  assign inv_now = (slot_i == 6'h00) ? line_o : inv_r;
  assign pre_lvl = pre_i[3'h7 - slot_i[2:0]] ^ inv_now;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      line_o <= 1'b0;
      inv_r  <= 1'b0;
    end
    else if (ce_i && tick_i)
    begin
      inv_r <= inv_now;
      if (slot_i < `BPAO_PRE_SLOTS)
        line_o <= pre_lvl;
      else if (!slot_i[0])
        line_o <= ~line_o;
      else
        line_o <= line_o ^ word_i[slot_i[5:1]];
    end
  end

endmodule

// ---- bpao_top.v ----
/*
  Bi-phase mark digital audio transmitter with a classic Wishbone slave.
  Assumes same-clock decoder inputs and a half-cell tick at 128 fs.
*/
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`include "bpao_map.vh"

// Overview of operation
// - Source select: pin low, pre, post.
// - CD-ROM format forces pre-processing source.
// - 32-bit subframes in bi-phase mark code.
// - Blocks of 384 words, block preamble marks start.
// - Slots 0-7 are coding-violating preamble.
// - Three preambles: block-left, left, right.
// - Aux bits zero; bit 4 flag optionally.
// - Sample bits 12-27, bits 8-11 zero.
// - Bit 28 marks uncorrectable error, any source.
// - Bit 29 carries free-running subcode stream.
// - Bit 31 gives even parity 4-31.
// - Left and right alternate, left first.
// - Bit 30 channel status, same per frame; the frame 0 right word rereads q_ctrl_i live instead of q_hold_r.
// - Status bits 0-3 copy Q control.
// - Status bits 8-15 category, bit 8 set.
// - Status bits 28-29 report clock accuracy.
// - All other status bits zero.
module bpao_top
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        half_tick_i,
  input  wire        cdrom_fmt_i,
  input  wire [15:0] pre_left_i,
  input  wire [15:0] pre_right_i,
  input  wire [15:0] post_left_i,
  input  wire [15:0] post_right_i,
  input  wire [1:0]  uncorr_err_i,
  input  wire [1:0]  correction_error_flag_i,
  input  wire        subcode_bit_i,
  input  wire [3:0]  q_ctrl_i,
  output reg         sample_req_o,
  output reg         subcode_ack_o,
  output reg         biphase_audio_out_pin_o
);

  ////////////////////////////////////////////////////////////////////////
  // Control register and bus slave

  reg  [4:0]  ctrl_r;
  wire [1:0]  src_sel;
  wire        flag_ins;
  wire [1:0]  acc_sel;
  wire        use_pre;
  wire        line_off;
  wire        bus_req;

  assign src_sel  = ctrl_r[`BPAO_CTRL_SRC_MSB:`BPAO_CTRL_SRC_LSB];
  assign flag_ins = ctrl_r[`BPAO_CTRL_FLAG];
  assign acc_sel  = ctrl_r[`BPAO_CTRL_ACC_MSB:`BPAO_CTRL_ACC_LSB];
  // Unused select code behaves like the pin-low setting
  assign line_off = (src_sel != `BPAO_SRC_PRE) && (src_sel != `BPAO_SRC_POST);
  assign use_pre  = (src_sel == `BPAO_SRC_PRE) || cdrom_fmt_i;
  assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;

  ////////////////////////////////////////////////////////////////////////
  // Subframe sequencing

  reg  [5:0]  slot_r;
  reg         side_r;
  reg  [7:0]  frame_r;
  reg  [31:0] word_r;
  reg  [7:0]  pre_r;
  reg  [15:0] right_hold_r;
  reg         right_err_r;
  reg         right_flag_r;
  reg  [3:0]  q_hold_r;
  wire        enc_line;

  wire        nxt_side;
  wire [7:0]  nxt_frame;
  wire        word_load;
  wire [15:0] nxt_sample;
  wire        nxt_err;
  wire        nxt_flag;
  wire [3:0]  q_use;
  reg         cs_bit;
  wire [30:0] body;

  assign word_load = ce_i && half_tick_i && (slot_r == `BPAO_LAST_SLOT);
  assign nxt_side  = ~side_r;
  assign nxt_frame = !side_r ? frame_r :
                     (frame_r == `BPAO_LAST_FRAME) ? 8'h00 : frame_r + 8'h01;
  // Left sample is taken live, right one is held for the next subframe
  assign nxt_sample = nxt_side ? right_hold_r : (use_pre ? pre_left_i : post_left_i);
  assign nxt_err    = nxt_side ? right_err_r  : uncorr_err_i[0];
  assign nxt_flag   = nxt_side ? right_flag_r : correction_error_flag_i[0];
  assign q_use      = (nxt_frame == 8'h00) ? q_ctrl_i : q_hold_r;

  always @*
  begin
    cs_bit = 1'b0;
    if (nxt_frame < 8'h04)
      cs_bit = q_use[nxt_frame[1:0]];
    else if (nxt_frame == 8'h08)
      cs_bit = 1'b1;
    else if (nxt_frame == 8'h1c)
      cs_bit = (acc_sel == `BPAO_ACC_LVL1);
    else if (nxt_frame == 8'h1d)
      cs_bit = (acc_sel == `BPAO_ACC_LVL3);
  end

  assign body = {cs_bit,
                 subcode_bit_i,
                 nxt_err,
                 nxt_sample,
                 4'h0,
                 3'h0,
                 flag_ins & nxt_flag,
                 4'h0};

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      slot_r        <= 6'h00;
      side_r        <= 1'b1;
      frame_r       <= `BPAO_LAST_FRAME;
      word_r        <= 32'h00000000;
      pre_r         <= `BPAO_PRE_RIGHT;
      right_hold_r  <= 16'h0000;
      right_err_r   <= 1'b0;
      right_flag_r  <= 1'b0;
      q_hold_r      <= 4'h0;
      sample_req_o  <= 1'b0;
      subcode_ack_o <= 1'b0;
    end
    else if (ce_i)
    begin
      sample_req_o  <= 1'b0;
      subcode_ack_o <= 1'b0;
      if (half_tick_i)
        slot_r <= slot_r + 6'h01;
      if (word_load)
      begin
        side_r        <= nxt_side;
        frame_r       <= nxt_frame;
        word_r        <= {^body[30:4], body};
        subcode_ack_o <= 1'b1;
        if (!nxt_side)
        begin
          pre_r        <= (nxt_frame == 8'h00) ? `BPAO_PRE_BLOCK : `BPAO_PRE_LEFT;
          right_hold_r <= use_pre ? pre_right_i : post_right_i;
          right_err_r  <= uncorr_err_i[1];
          right_flag_r <= correction_error_flag_i[1];
          sample_req_o <= 1'b1;
          if (nxt_frame == 8'h00)
            q_hold_r <= q_ctrl_i;
        end
        else
          pre_r <= `BPAO_PRE_RIGHT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line encoder and pin

  bpao_bmc_enc u_enc
  (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .tick_i (half_tick_i),
    .slot_i (slot_r),
    .word_i (word_r),
    .pre_i  (pre_r),
    .line_o (enc_line)
  );

  // Forcing low is also how software parks the line around audio-off
  always @(posedge clk_i)
  begin
    if (rst_i)
      biphase_audio_out_pin_o <= 1'b0;
    else if (ce_i)
      biphase_audio_out_pin_o <= line_off ? 1'b0 : enc_line;
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone register access

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r   <= `BPAO_CTRL_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h00000000;
      if (bus_req)
      begin
        if (wb_we_i && wb_adr_i == `BPAO_ADR_CTRL && wb_sel_i[0])
          ctrl_r <= wb_dat_i[4:0];
        if (!wb_we_i && wb_adr_i == `BPAO_ADR_CTRL)
          wb_dat_o <= {27'h0000000, ctrl_r};
        if (!wb_we_i && wb_adr_i == `BPAO_ADR_STAT)
          wb_dat_o <= {21'h000000, !line_off, use_pre, side_r, frame_r};
      end
    end
  end

endmodule

// ---- bpao_checker.sv ----
/*
  Port checker for the bi-phase transmitter: bus handshake, load pacing, line.
  Assumes one clock domain; bound to the top module below.
*/
`timescale 1ns/1ns
module bpao_checker
(
  input wire        clk_i,
  input wire        rst_i,
  input wire        ce_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        half_tick_i,
  input wire        sample_req_o,
  input wire        subcode_ack_o,
  input wire        biphase_audio_out_pin_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle:
    assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack too long");
  a_ack_after_req:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o) else $error("no ack");
  a_ack_needs_req:
    assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("stray ack");
  a_dat_idle_zero:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
  a_reset_quiet:
    assert property ($fell(rst_i) |-> !biphase_audio_out_pin_o && !sample_req_o) else $error("busy");
  a_left_is_load:
    assert property (sample_req_o |-> subcode_ack_o) else $error("pair without load");
  a_load_gap:
    assert property (subcode_ack_o |=> !subcode_ack_o [*8]) else $error("loads too close");
  a_load_on_tick:
    assert property ($rose(subcode_ack_o) |-> $past(half_tick_i)) else $error("load off tick");
  a_rise_on_tick:
    assert property ($rose(biphase_audio_out_pin_o) |-> $past(half_tick_i, 2)) else $error("edge");
endmodule

bind bpao_top bpao_checker u_chk
(
  .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .half_tick_i,
  .sample_req_o, .subcode_ack_o, .biphase_audio_out_pin_o
);

// ---- bpao_rx_model.sv ----
/*
  Receiver model: samples each half-cell, finds the preamble, decodes words.
  Assumes half-cell ticks at least two clocks apart.
*/
`timescale 1ns/1ns
module bpao_rx_model
(
  input  wire        clk_i,
  input  wire        tick_i,
  input  wire        line_i,
  output reg         word_vld_o,
  output reg  [35:0] word_o,
  output reg         cell_err_o = 1'b0
);
  reg  [2:0]  td_r = 3'h0;
  reg  [63:0] sr_r = 64'h0;
  reg  [6:0]  cnt_r = 7'h7f;
  wire [63:0] sh = {sr_r[62:0], line_i};
  integer     k;
  // Line is sampled two clocks after it settles from the tick
  always @(posedge clk_i)
  begin
    td_r <= {td_r[1:0], tick_i};
    word_vld_o <= 1'b0;
    if (td_r[2])
    begin
      sr_r <= sh;
      // Runs of three only occur in a preamble; runs late in one are ignored
      cnt_r <= (cnt_r > 7'h07 && (&sh[2:0] || ~|sh[2:0])) ? 7'h02 : cnt_r + 7'h01;
      if (cnt_r == 7'h3e)
      begin
        word_vld_o <= 1'b1;
        word_o[35:28] <= sh[63] ? sh[63:56] : ~sh[63:56];
        for (k = 4; k < 32; k = k + 1)
        begin
          word_o[k-4] <= sh[63-2*k] ^ sh[62-2*k];
          if (sh[63-2*k] == sh[64-2*k])
            cell_err_o <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- test_biphase_digital_audio_out.sv ----
/*
  Bench: random samples, flags, subcode and settings each frame, decoded back.
  Assumes the receiver model and the bound checker are compiled with it.
*/
`timescale 1ns/1ns
`include "bpao_map.vh"
module test_biphase_digital_audio_out;
  reg         clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  reg         wb_we_i = 1'b0, half_tick_i = 1'b0, cdrom_fmt_i = 1'b0, subcode_bit_i = 1'b1;
  reg  [7:0]  wb_adr_i = 8'h00;
  reg  [3:0]  wb_sel_i = 4'hf, q_ctrl_i = 4'hc, qlat;
  reg  [31:0] wb_dat_i = 32'h0, rd;
  reg  [15:0] pre_left_i = 16'h8000, pre_right_i = 16'h7fff;
  reg  [15:0] post_left_i = 16'hffff, post_right_i = 16'h0001;
  reg  [1:0]  uncorr_err_i = 2'h1, correction_error_flag_i = 2'h2;
  reg  [4:0]  ctrl = 5'h0e;
  reg         go = 1'b0, seen = 1'b0;
  reg  [35:0] expq[$];
  wire [31:0] wb_dat_o;
  wire [35:0] w;
  wire        wb_ack_o, sample_req_o, subcode_ack_o, biphase_audio_out_pin_o, vld, cerr;
  integer     fr = -1, error_cnt = 0, checked = 0, s;

  bpao_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .half_tick_i(half_tick_i), .cdrom_fmt_i(cdrom_fmt_i), .pre_left_i(pre_left_i),
    .pre_right_i(pre_right_i), .post_left_i(post_left_i), .post_right_i(post_right_i),
    .uncorr_err_i(uncorr_err_i), .correction_error_flag_i(correction_error_flag_i),
    .subcode_bit_i(subcode_bit_i), .q_ctrl_i(q_ctrl_i), .sample_req_o(sample_req_o),
    .subcode_ack_o(subcode_ack_o), .biphase_audio_out_pin_o(biphase_audio_out_pin_o));
  bpao_rx_model u_rx (.clk_i, .tick_i(half_tick_i), .line_i(biphase_audio_out_pin_o),
    .word_vld_o(vld), .word_o(w), .cell_err_o(cerr));

  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) half_tick_i <= go & ~half_tick_i;
  ////////////////////////////////////////////////////////////////////////////
  function [35:0] exp_w(input rt, input [7:0] fi);
    reg [31:0] x;
    begin
      x = 32'h0;
      x[4] = ctrl[2] & correction_error_flag_i[rt];
      x[27:12] = (cdrom_fmt_i || ctrl[1:0] == `BPAO_SRC_PRE) ?
        (rt ? pre_right_i : pre_left_i) : (rt ? post_right_i : post_left_i);
      x[28] = uncorr_err_i[rt];
      x[29] = subcode_bit_i;
      x[30] = (fi < 4) ? qlat[fi[1:0]] : (fi == 8 ||
        (fi == 28 && ctrl[4:3] == `BPAO_ACC_LVL1) || (fi == 29 && ctrl[4:3] == `BPAO_ACC_LVL3));
      x[31] = ^x[30:4];
      exp_w = {rt ? `BPAO_PRE_RIGHT : (fi == 0 ? `BPAO_PRE_BLOCK : `BPAO_PRE_LEFT), x[31:4]};
    end
  endfunction

  task chk(input [35:0] e, input [35:0] g);
    begin
      checked = checked + 1;
      if (e !== g)
      begin
        error_cnt = error_cnt + 1;
        $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask

  task wb(input wr, input [7:0] a, input [31:0] d);
    begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, wr, a, d};
      @(posedge clk_i);
      while (!wb_ack_o) @(posedge clk_i);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      @(posedge clk_i);
    end
  endtask

  task complete_run;
    begin
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // The first decoded word is the dummy sent before any load
  always @(posedge clk_i)
    if (subcode_ack_o)
    begin
      if (sample_req_o)
        fr = (fr + 1) % 192;
      if (sample_req_o && fr == 0)
        qlat = q_ctrl_i;
      expq.push_back(exp_w(!sample_req_o, fr[7:0]));
    end

  always @(posedge clk_i)
    if (vld)
    begin
      if (seen && expq.size() > 0)
        chk(expq.pop_front(), w);
      seen = 1'b1;
    end

  initial
  begin
    #400000;
    error_cnt = error_cnt + 1;
    complete_run;
  end

  initial
  begin
    s = $urandom(60460);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, `BPAO_ADR_CTRL, {27'h0, ctrl});
    wb(1'b0, `BPAO_ADR_CTRL, 32'h0);
    chk({27'h0, ctrl}, rd);
    wb(1'b0, 8'h10, 32'h0);
    chk(36'h0, rd);
    $display("register test done");
    go <= 1'b1;
    // New values land just after a right word, so both words of a pair share them
    repeat (251)
    begin
      @(posedge clk_i);
      while (!(subcode_ack_o && !sample_req_o)) @(posedge clk_i);
      {pre_left_i, pre_right_i, post_left_i, post_right_i} <= {$urandom, $urandom};
      {uncorr_err_i, correction_error_flag_i, q_ctrl_i, cdrom_fmt_i, subcode_bit_i} <= 10'($urandom);
      s = ($urandom % 3) * 8 + ($urandom % 2) * 4 + 1 + $urandom % 2;
      wb(1'b1, `BPAO_ADR_CTRL, s);
      ctrl = s[4:0];
    end
    $display("stream test done");
    // Unused select code 3 must park the line just like code 0
    wb(1'b1, `BPAO_ADR_CTRL, 32'h3);
    repeat (8) @(posedge clk_i);
    repeat (200)
    begin
      @(posedge clk_i);
      chk(36'h0, biphase_audio_out_pin_o);
    end
    wb(1'b1, `BPAO_ADR_CTRL, {27'h0, `BPAO_CTRL_RST});
    repeat (8) @(posedge clk_i);
    repeat (200)
    begin
      @(posedge clk_i);
      chk(36'h0, biphase_audio_out_pin_o);
    end
    wb(1'b0, `BPAO_ADR_STAT, 32'h0);
    chk({35'h0, cdrom_fmt_i}, {26'h0, rd[10:9]});
    chk(36'h0, cerr);
    $display("off test done");
    complete_run;
  end
endmodule
